//--- shared/dma_req_map.svh
// offsets, field positions, reset values and counts of the request and priority block
`ifndef DMA_REQ_MAP_SVH
`define DMA_REQ_MAP_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define OFS_CHAN_CTRL0  8'h00
`define OFS_CHAN_CTRL1  8'h04
`define OFS_CHAN_CTRL2  8'h08
`define OFS_CHAN_CTRL3  8'h0C
`define OFS_OP_CTRL     8'h10
`define OFS_STATUS      8'h14

// ----------------------------------------------------------------
// channel_control fields
// ----------------------------------------------------------------
`define CC_EN_BIT       0
`define CC_SENSE_BIT    1
`define CC_BURST_BIT    2
`define CC_SRC_LSB      4

// ----------------------------------------------------------------
// operation_control and status fields
// ----------------------------------------------------------------
`define OC_MASTER_BIT   0
`define OC_PRIO_LO_BIT  8
`define OC_PRIO_HI_BIT  9
`define ST_PEND_LSB     0
`define ST_BUSY_BIT     4
`define ST_CH_LSB       8
`define ST_TOP_LSB      12

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define RST_PRIO_SEL    2'h0
`define RST_RR_TOP      2'h0
`define PRIO_RR         2'h3
`define SYNC_STAGES     3

`endif

//--- shared/dma_req_pkg.sv
// types shared by the request and priority block
package dma_req_pkg;

  typedef enum logic [0:0] {
    ARB_IDLE = 1'b0,
    ARB_BUSY = 1'b1
  } arb_state_type;

  typedef struct packed {
    logic       capture;
    logic       fifo_rx_full;
    logic       fifo_tx_empty;
    logic       plain_rx_full;
    logic       plain_tx_empty;
  } periph_req_type;

  typedef struct packed {
    logic [3:0] request_source_select;
    logic       burst;
    logic       request_sense_select;
    logic       channel_enable;
  } chan_cfg_type;

  typedef struct packed {
    logic [2:0] sync;
    logic       level_n;
    logic       held;
  } sense_state_type;

  typedef struct packed {
    chan_cfg_type [3:0] cfg;
    logic               master_enable;
    logic [1:0]         prio_sel;
    arb_state_type      st;
    logic               grant_valid;
    logic [1:0]         grant_ch;
    logic [1:0]         rr_top;
    periph_req_type     withdraw;
    logic [31:0]        rdata;
  } arb_state_type_all_type;

endpackage : dma_req_pkg

//--- logic/chan_request_sense.sv
// external request pin sensing for one channel
`timescale 1ns/1ns
`default_nettype none
`include "dma_req_map.svh"

module chan_request_sense
  import dma_req_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // pin and setting
  input  wire logic ext_xfer_request_n,
  input  wire logic request_sense_select,
  // control from the arbiter
  input  wire logic block,
  input  wire logic cancel,
  input  wire logic consume,
  // result
  output logic      req,
  output logic      held
);

  sense_state_type s_r;
  sense_state_type s_nxt;
  logic            fall;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt      = s_r;
    s_nxt.sync = {s_r.sync[1:0], ext_xfer_request_n};
    // a change counts once the second and third stages agree
    if (s_r.sync[1] == s_r.sync[2]) begin
      s_nxt.level_n = s_r.sync[2];
    end
    fall = s_r.level_n & ~s_nxt.level_n;
    if (cancel || !request_sense_select) begin
      s_nxt.held = 1'b0;
    end else if (fall && !block) begin
      s_nxt.held = 1'b1;
    end else if (consume) begin
      s_nxt.held = 1'b0;
    end
  end

  // idle line is high, so the filtered level starts high
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '{sync: 3'h7, level_n: 1'b1, held: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign req  = request_sense_select ? s_r.held : ~s_r.level_n;
  assign held = s_r.held;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_level_drops_latch;
    @(posedge sys_clk) disable iff (sys_rst)
    !request_sense_select |=> !held;
  endproperty
  a_level_drops_latch: assert property (p_level_drops_latch)
    else $error("latch survived level mode");

  property p_flag_cancels;
    @(posedge sys_clk) disable iff (sys_rst)
    cancel |=> !held;
  endproperty
  a_flag_cancels: assert property (p_flag_cancels)
    else $error("latch survived error flag");

endmodule : chan_request_sense
`default_nettype wire

//--- logic/dma_request_and_priority.sv
// request intake and channel arbitration for a four-channel dma controller
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "dma_req_map.svh"


module dma_request_and_priority
  import dma_req_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // external request pins
  input  wire logic [3:0]        ext_xfer_request_n,
  // on-chip peripheral requests
  input  wire periph_req_type    periph_req,
  output periph_req_type         periph_withdraw,
  // flags owned by the controller
  input  wire logic [3:0]        transfer_end_flag,
  input  wire logic              nonmaskable_intr_flag,
  input  wire logic              address_error_flag,
  // transfer engine handshake
  input  wire logic              unit_done,
  input  wire logic              unit_last,
  output logic                   grant_valid,
  output logic      [1:0]        grant_ch
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one-hot of the peripheral source that a code selects
  function automatic periph_req_type src_mask(input logic [3:0] code);
    periph_req_type m;
    m = '0;
    case (code)
      4'h8: m.plain_tx_empty = 1'b1;
      4'h9: m.plain_rx_full  = 1'b1;
      4'hA: m.fifo_tx_empty  = 1'b1;
      4'hB: m.fifo_rx_full   = 1'b1;
      4'hC, 4'hD, 4'hE: m.capture = 1'b1;
      default: m = '0;
    endcase
    return m;
  endfunction : src_mask

  // channel standing at a priority position
  function automatic logic [1:0] chan_at(input logic [1:0] sel,
                                         input logic [1:0] top,
                                         input logic [1:0] pos);
    logic [1:0] c;
    c = pos;
    case (sel)
      2'h0: c = pos;
      2'h1: begin
        case (pos)
          2'h0: c = 2'h0;
          2'h1: c = 2'h2;
          2'h2: c = 2'h3;
          default: c = 2'h1;
        endcase
      end
      2'h2: begin
        case (pos)
          2'h0: c = 2'h2;
          2'h1: c = 2'h0;
          2'h2: c = 2'h1;
          default: c = 2'h3;
        endcase
      end
      default: c = 2'(top + pos);
    endcase
    return c;
  endfunction : chan_at

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  arb_state_type_all_type s_r;
  arb_state_type_all_type s_nxt;

  logic [3:0] ok;
  logic [3:0] want;
  logic [3:0] ext_req;
  logic [3:0] ext_held;
  logic [3:0] consume;
  logic       found;
  logic [1:0] pick;
  logic       flags_bad;

  assign flags_bad = nonmaskable_intr_flag | address_error_flag;

  // ----------------------------------------------------------------
  // external request sensing, one per channel
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 4; g++) begin : g_sense
    assign consume[g] = (s_r.st == ARB_BUSY) && unit_done &&
                        (s_r.grant_ch == 2'(g));
    chan_request_sense u_sense (
      .sys_clk              (sys_clk),
      .sys_rst              (sys_rst),
      .ext_xfer_request_n   (ext_xfer_request_n[g]),
      .request_sense_select (s_r.cfg[g].request_sense_select),
      .block                (transfer_end_flag[g] | flags_bad),
      .cancel               (flags_bad),
      .consume              (consume[g]),
      .req                  (ext_req[g]),
      .held                 (ext_held[g])
    );
  end

  // ----------------------------------------------------------------
  // eligibility and priority pick
  // ----------------------------------------------------------------
  always_comb begin
    ok    = '0;
    want  = '0;
    found = 1'b0;
    pick  = 2'h0;
    for (int c = 0; c < 4; c++) begin
      ok[c] = s_r.cfg[c].channel_enable & s_r.master_enable &
              ~transfer_end_flag[c] & ~flags_bad;
      if (s_r.cfg[c].request_source_select[3]) begin
        // a source being withdrawn this cycle is not taken again
        want[c] = ok[c] & |(src_mask(s_r.cfg[c].request_source_select) &
                            periph_req & ~s_r.withdraw);
      end else begin
        want[c] = ok[c] & ext_req[c];
      end
    end
    // lowest position wins, so scan from the bottom up
    for (int p = 3; p >= 0; p--) begin
      if (want[chan_at(s_r.prio_sel, s_r.rr_top, 2'(p))]) begin
        found = 1'b1;
        pick  = chan_at(s_r.prio_sel, s_r.rr_top, 2'(p));
      end
    end
  end

  // ----------------------------------------------------------------
  // next state: registers, arbiter, withdraw
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0]  rv;
    logic [3:0]   others;
    chan_cfg_type gc;
    rv     = '0;
    others = '0;
    gc     = s_r.cfg[s_r.grant_ch];
    s_nxt  = s_r;
    s_nxt.withdraw = '0;
    s_nxt.rdata    = '0;

    // register writes
    if (reg_wr) begin
      if (reg_addr == ADDR_W'(`OFS_OP_CTRL)) begin
        s_nxt.master_enable = reg_wdata[`OC_MASTER_BIT];
        s_nxt.prio_sel = {reg_wdata[`OC_PRIO_HI_BIT], reg_wdata[`OC_PRIO_LO_BIT]};
      end else if (reg_addr[ADDR_W-1:4] == '0 && reg_addr[1:0] == 2'h0) begin
        s_nxt.cfg[reg_addr[3:2]] = '{
          request_source_select: reg_wdata[`CC_SRC_LSB +: 4],
          burst:                 reg_wdata[`CC_BURST_BIT],
          request_sense_select:  reg_wdata[`CC_SENSE_BIT],
          channel_enable:        reg_wdata[`CC_EN_BIT]};
      end
    end

    // register reads, data in the following cycle only
    if (reg_rd) begin
      if (reg_addr == ADDR_W'(`OFS_OP_CTRL)) begin
        rv[`OC_MASTER_BIT]  = s_r.master_enable;
        rv[`OC_PRIO_LO_BIT] = s_r.prio_sel[0];
        rv[`OC_PRIO_HI_BIT] = s_r.prio_sel[1];
      end else if (reg_addr == ADDR_W'(`OFS_STATUS)) begin
        rv[`ST_PEND_LSB +: 4] = ext_held;
        rv[`ST_BUSY_BIT]      = s_r.grant_valid;
        rv[`ST_CH_LSB +: 2]   = s_r.grant_ch;
        rv[`ST_TOP_LSB +: 2]  = s_r.rr_top;
      end else if (reg_addr[ADDR_W-1:4] == '0 && reg_addr[1:0] == 2'h0) begin
        rv[`CC_SRC_LSB +: 4] = s_r.cfg[reg_addr[3:2]].request_source_select;
        rv[`CC_BURST_BIT]    = s_r.cfg[reg_addr[3:2]].burst;
        rv[`CC_SENSE_BIT]    = s_r.cfg[reg_addr[3:2]].request_sense_select;
        rv[`CC_EN_BIT]       = s_r.cfg[reg_addr[3:2]].channel_enable;
      end
      s_nxt.rdata = rv;
    end

    // arbiter
    case (s_r.st)
      ARB_IDLE: begin
        if (found) begin
          s_nxt.st          = ARB_BUSY;
          s_nxt.grant_valid = 1'b1;
          s_nxt.grant_ch    = pick;
        end
      end
      ARB_BUSY: begin
        if (unit_done) begin
          s_nxt.st          = ARB_IDLE;
          s_nxt.grant_valid = 1'b0;
          if (!gc.burst || unit_last) begin
            s_nxt.withdraw = src_mask(gc.request_source_select);
          end
          others = want & ~(4'h1 << s_r.grant_ch);
          if (others == '0) begin
            s_nxt.rr_top = `RST_RR_TOP;
          end else begin
            s_nxt.rr_top = 2'(s_r.grant_ch + 2'h1);
          end
        end else if (!ok[s_r.grant_ch]) begin
          // suspension: enable or flag lost mid-unit
          s_nxt.st          = ARB_IDLE;
          s_nxt.grant_valid = 1'b0;
        end
      end
      default: s_nxt.st = ARB_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '{cfg: '0, master_enable: 1'b0, prio_sel: `RST_PRIO_SEL,
               st: ARB_IDLE, grant_valid: 1'b0, grant_ch: 2'h0,
               rr_top: `RST_RR_TOP, withdraw: '0, rdata: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata       = s_r.rdata;
  assign periph_withdraw = s_r.withdraw;
  assign grant_valid     = s_r.grant_valid;
  assign grant_ch        = s_r.grant_ch;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  logic gc_src_periph;
  logic en_all;
  assign gc_src_periph = s_r.cfg[s_r.grant_ch].request_source_select[3] &&
                         (src_mask(s_r.cfg[s_r.grant_ch].request_source_select) != '0);
  assign en_all        = s_r.master_enable & ~flags_bad;

  sequence s_unit_end;
    s_r.st == ARB_BUSY && unit_done;
  endsequence

  sequence s_periph_unit_end;
    s_unit_end ##0 gc_src_periph;
  endsequence

  property p_grant_needs_enable;
    $rose(grant_valid) |-> $past(en_all);
  endproperty
  a_grant_needs_enable: assert property (p_grant_needs_enable)
    else $error("grant without enable");

  property p_grant_pick;
    (s_r.st == ARB_IDLE && found) |=> grant_valid && grant_ch == $past(pick);
  endproperty
  a_grant_pick: assert property (p_grant_pick)
    else $error("grant not the picked channel");

  property p_fixed_order_b;
    (s_r.st == ARB_IDLE && s_r.prio_sel == 2'h1 && want == 4'hA) |=> grant_ch == 2'h3;
  endproperty
  a_fixed_order_b: assert property (p_fixed_order_b)
    else $error("order 0>2>3>1 broken");

  property p_fixed_order_c;
    (s_r.st == ARB_IDLE && s_r.prio_sel == 2'h2 && want[0] && want[2]) |=> grant_ch == 2'h2;
  endproperty
  a_fixed_order_c: assert property (p_fixed_order_c)
    else $error("order 2>0>1>3 broken");

  property p_rr_rotate;
    (s_unit_end ##0 (want & ~(4'h1 << s_r.grant_ch)) != '0)
      |=> s_r.rr_top == 2'($past(s_r.grant_ch) + 2'h1);
  endproperty
  a_rr_rotate: assert property (p_rr_rotate)
    else $error("rotation lost cyclic order");

  property p_rr_restore;
    (s_unit_end ##0 (want & ~(4'h1 << s_r.grant_ch)) == '0) |=> s_r.rr_top == 2'h0;
  endproperty
  a_rr_restore: assert property (p_rr_restore)
    else $error("idle order not restored");

  property p_withdraw_steal;
    (s_periph_unit_end ##0 (!s_r.cfg[s_r.grant_ch].burst || unit_last))
      |=> periph_withdraw != '0 ##1 periph_withdraw == '0;
  endproperty
  a_withdraw_steal: assert property (p_withdraw_steal)
    else $error("request not withdrawn");

  property p_no_withdraw_mid_burst;
    (s_unit_end ##0 s_r.cfg[s_r.grant_ch].burst && !unit_last) |=> periph_withdraw == '0;
  endproperty
  a_no_withdraw_mid_burst: assert property (p_no_withdraw_mid_burst)
    else $error("withdraw before last burst unit");

  property p_hold_during_unit;
    (grant_valid && !unit_done && ok[grant_ch]) |=> grant_valid && $stable(grant_ch);
  endproperty
  a_hold_during_unit: assert property (p_hold_during_unit)
    else $error("grant moved inside a unit");

  property p_unit_end_rearb;
    s_unit_end |=> !grant_valid;
  endproperty
  a_unit_end_rearb: assert property (p_unit_end_rearb)
    else $error("no rearbitration slot at unit end");

endmodule : dma_request_and_priority
`default_nettype wire

//--- bench/dma_far_side_model.sv
// far-side model: external requesters, on-chip request sources, transfer engine
`timescale 1ns/1ns
`default_nettype none

module dma_far_side_model
  import dma_req_pkg::*;
(
  // clock and reset
  input  wire logic           sys_clk,
  input  wire logic           sys_rst,
  // commands from the bench
  input  wire logic [3:0]     pin_low,
  input  wire logic [4:0]     raise,
  input  wire logic [3:0]     done_wait,
  input  wire logic           last,
  // block side
  input  wire logic           grant_valid,
  input  wire periph_req_type periph_withdraw,
  output logic [3:0]          ext_xfer_request_n,
  output periph_req_type      periph_req,
  output logic                unit_done,
  output logic                unit_last
);
  logic       run_r;
  logic [3:0] cnt_r;

  // idle requesters keep the line high
  assign ext_xfer_request_n = ~pin_low;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      periph_req <= '0;
      run_r      <= 1'b0;
      cnt_r      <= 4'h0;
      unit_done  <= 1'b0;
      unit_last  <= 1'b0;
    end else begin
      // raise stands for a source whose own enable is already set
      periph_req <= periph_req_type'((periph_req & ~periph_withdraw) | raise);
      unit_last  <= last;
      // engine: slow or prompt, one done pulse per grant
      if (!grant_valid) begin
        run_r     <= 1'b0;
        cnt_r     <= 4'h0;
        unit_done <= 1'b0;
      end else if (!run_r) begin
        run_r <= 1'b1;
        cnt_r <= done_wait;
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end else begin
        unit_done <= !unit_done;
      end
    end
  end
endmodule : dma_far_side_model

`default_nettype wire

//--- bench/dma_request_and_priority_bench.sv
// self-checking bench for request intake and channel arbitration
`timescale 1ns/1ns
`default_nettype none

module dma_request_and_priority_bench
  import dma_req_pkg::*;
;
  logic           sys_clk, sys_rst, reg_wr, reg_rd, last, rd_seen, gv_prev;
  logic [7:0]     reg_addr, lfsr;
  logic [31:0]    reg_wdata, reg_rdata;
  logic [3:0]     ext_xfer_request_n, transfer_end_flag, pin_low, done_wait;
  periph_req_type periph_req, periph_withdraw;
  logic           nonmaskable_intr_flag, address_error_flag, unit_done, unit_last, grant_valid;
  logic [1:0]     grant_ch;
  logic [4:0]     raise, m;
  logic [31:0]    rd_q[$];
  logic [1:0]     gnt_q[$];
  logic [4:0]     wd_q[$];
  logic [7:0]     ord [4] = '{8'hE4, 8'h78, 8'hD2, 8'hE4};
  int             err_total, n_compared, n_grant, base, p, k, f, c;

  dma_request_and_priority #(.ADDR_W(8)) u_dma_request_and_priority (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_xfer_request_n(ext_xfer_request_n), .periph_req(periph_req),
    .periph_withdraw(periph_withdraw), .transfer_end_flag(transfer_end_flag),
    .nonmaskable_intr_flag(nonmaskable_intr_flag), .address_error_flag(address_error_flag),
    .unit_done(unit_done), .unit_last(unit_last), .grant_valid(grant_valid),
    .grant_ch(grant_ch));

  dma_far_side_model u_dma_far_side_model (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .pin_low(pin_low), .raise(raise),
    .done_wait(done_wait), .last(last), .grant_valid(grant_valid),
    .periph_withdraw(periph_withdraw), .ext_xfer_request_n(ext_xfer_request_n),
    .periph_req(periph_req), .unit_done(unit_done), .unit_last(unit_last));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  task print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
  endtask : rd

  // low long enough to pass the three sync stages, then idle high
  task pin_pulse(input logic [3:0] msk);
    @(posedge sys_clk);
    pin_low <= msk;
    repeat (4) @(posedge sys_clk);
    pin_low <= 4'h0;
    repeat (4) @(posedge sys_clk);
  endtask : pin_pulse

  task raise_src(input logic [4:0] msk);
    @(posedge sys_clk);
    raise <= msk;
    @(posedge sys_clk);
    raise <= 5'h00;
  endtask : raise_src

  task wait_idle();
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge sys_clk);
      if (gnt_q.size() == 0 && wd_q.size() == 0 && rd_q.size() == 0 && !grant_valid) break;
    end
    if (i == 400) begin
      chk("idle wait", 32'h0000_0000, 32'h0000_0001);
      print_verdict();
    end else begin
      repeat (2) @(posedge sys_clk);
    end
  endtask : wait_idle

  task wait_grant(input int n);
    int i;
    for (i = 0; i < 300; i++) begin
      if (n_grant >= n) break;
      @(posedge sys_clk);
    end
    if (i == 300) begin
      chk("grant count", 32'(n), 32'(n_grant));
      print_verdict();
    end
  endtask : wait_grant

  // ----------------------------------------------------------------
  // watcher: oldest note against each result as it appears
  // ----------------------------------------------------------------
  always @(negedge sys_clk) begin
    if (rd_seen && rd_q.size() > 0) chk("reg_rdata", rd_q.pop_front(), reg_rdata);
    rd_seen = reg_rd;
    if (grant_valid === 1'b1 && gv_prev !== 1'b1) begin
      n_grant++;
      chk("grant_ch", gnt_q.size() > 0 ? 32'(gnt_q.pop_front()) : 32'hFFFF_FFFF, 32'(grant_ch));
    end
    gv_prev = grant_valid;
    if (periph_withdraw !== 5'h00) begin
      chk("periph_withdraw", wd_q.size() > 0 ? 32'(wd_q.pop_front()) : 32'hFFFF_FFFF,
          32'(periph_withdraw));
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    transfer_end_flag = 4'h0;
    nonmaskable_intr_flag = 1'b0;
    address_error_flag = 1'b0;
    pin_low = 4'h0;
    raise = 5'h00;
    done_wait = 4'h0;
    last = 1'b1;
    lfsr = 8'h4D;
    err_total = 0;
    n_compared = 0;
    n_grant = 0;
    rd_seen = 1'b0;
    gv_prev = 1'b0;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(8'h14, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    lfsr = lfsr_next(lfsr);
    wr(8'h20, {24'h00_0000, lfsr});
    rd(8'h20, 32'h0000_0000);
    for (k = 0; k < 4; k++) wr(8'(k * 4), 32'h0000_0003);
    // every priority code, all four pins falling together
    for (p = 0; p < 4; p++) begin
      wr(8'h10, 32'h0000_0001 | 32'(p << 8));
      for (k = 0; k < 4; k++) gnt_q.push_back(ord[p][2*k +: 2]);
      pin_pulse(4'hF);
      wait_idle();
    end
    rd(8'h10, 32'h0000_0301);
    // grant_ch keeps the last channel served (ch3) once the grant drops
    rd(8'h14, 32'h0000_0300);
    // round robin with late arrivals while a unit runs
    done_wait <= 4'hA;
    gnt_q = '{2'h0, 2'h1, 2'h3, 2'h0};
    base = n_grant;
    pin_pulse(4'h3);
    wait_grant(base + 2);
    pin_pulse(4'h9);
    wait_grant(base + 3);
    rd(8'h14, 32'h0000_2319);
    wait_idle();
    rd(8'h14, 32'h0000_0000);
    // held edge request: toggle cancel, then flag cancel
    wr(8'h10, 32'h0000_0000);
    pin_pulse(4'h1);
    rd(8'h14, 32'h0000_0001);
    wr(8'h00, 32'h0000_0001);
    wr(8'h00, 32'h0000_0003);
    rd(8'h14, 32'h0000_0000);
    for (f = 0; f < 2; f++) begin
      pin_pulse(4'h1);
      rd(8'h14, 32'h0000_0001);
      if (f == 0) nonmaskable_intr_flag <= 1'b1;
      else address_error_flag <= 1'b1;
      @(posedge sys_clk);
      rd(8'h14, 32'h0000_0000);
      nonmaskable_intr_flag <= 1'b0;
      address_error_flag <= 1'b0;
    end
    // no grant may follow the cancels
    wr(8'h10, 32'h0000_0001);
    repeat (20) @(posedge sys_clk);
    // every source code, cycle steal, held off by the end flag first
    for (c = 8; c < 15; c++) begin
      m = (c < 12) ? 5'(5'h01 << (c - 8)) : 5'h10;
      lfsr = lfsr_next(lfsr);
      done_wait <= lfsr[3:0];
      wr(8'h00, 32'(c << 4) | 32'h0000_0001);
      transfer_end_flag <= 4'h1;
      raise_src(m);
      repeat (6) @(posedge sys_clk);
      gnt_q.push_back(2'h0);
      wd_q.push_back(m);
      transfer_end_flag <= 4'h0;
      wait_idle();
    end
    // burst on capture: withdraw only after the final unit
    done_wait <= 4'h8;
    last <= 1'b0;
    wr(8'h00, 32'h0000_00C5);
    rd(8'h00, 32'h0000_00C5);
    gnt_q = '{2'h0, 2'h0};
    wd_q.push_back(5'h10);
    base = n_grant;
    raise_src(5'h10);
    wait_grant(base + 2);
    last <= 1'b1;
    wait_idle();
    // one capture event, two capture channels
    wr(8'h00, 32'h0000_0000);
    wr(8'h04, 32'h0000_00C1);
    wr(8'h08, 32'h0000_00C1);
    gnt_q.push_back(2'h1);
    wd_q.push_back(5'h10);
    raise_src(5'h10);
    wait_idle();
    repeat (10) @(posedge sys_clk);
    print_verdict();
  end
endmodule : dma_request_and_priority_bench

`default_nettype wire
